//--- cjmu_pkg.sv
// cjmu_pkg: constants, register map and carriers for the jump/move execution unit.
// assumes a 16-bit instruction word and a 20-bit program counter.
package cjmu_pkg;
    localparam int unsigned CJMU_PCW = 20;
    localparam int unsigned CJMU_NREG = 16;
    // register map, byte addresses on the axi4-lite slave
    localparam logic [7:0] CJMU_ADDR_CTRL = 8'h00;
    localparam logic [7:0] CJMU_ADDR_INSTR = 8'h04;
    localparam logic [7:0] CJMU_ADDR_SRCV = 8'h08;
    localparam logic [7:0] CJMU_ADDR_PC = 8'h0C;
    localparam logic [7:0] CJMU_ADDR_STATUS = 8'h10;
    localparam logic [7:0] CJMU_ADDR_RESULT = 8'h14;
    localparam logic [7:0] CJMU_ADDR_INFO = 8'h18;
    localparam logic [7:0] CJMU_ADDR_REGBASE = 8'h40;
    // status word bit positions
    localparam int unsigned CJMU_SR_C = 0;
    localparam int unsigned CJMU_SR_Z = 1;
    localparam int unsigned CJMU_SR_N = 2;
    localparam int unsigned CJMU_SR_GIE = 3;
    localparam int unsigned CJMU_SR_CORE_HALT_BIT_POS = 4;
    localparam int unsigned CJMU_SR_OSCILLATOR_HALT_BIT_POS = 5;
    localparam int unsigned CJMU_SR_V = 8;
    // reset values
    localparam logic [15:0] CJMU_SR_RST = 16'h0000;
    localparam logic [19:0] CJMU_PC_RST = 20'h00000;
    // opcode fields and bus response codes
    localparam logic [2:0] CJMU_JMP_PREFIX = 3'h1;
    localparam logic [3:0] CJMU_OP_COPY = 4'h4;
    localparam logic [3:0] CJMU_REG_CG2 = 4'h3;
    localparam logic [3:0] CJMU_REG_SR = 4'h2;
    localparam logic [1:0] CJMU_RSP = 2'h3;
    localparam logic [1:0] CJMU_RSP_SLVERR = 2'h2;
    localparam logic [31:0] CJMU_INFO_ID = 32'h0000C0DE; // arbitrary value

    typedef enum logic [2:0] {
        CJMU_CND_NZ, CJMU_CND_Z, CJMU_CND_NC, CJMU_CND_C,
        CJMU_CND_N, CJMU_CND_GE, CJMU_CND_L, CJMU_CND_AL
    } cjmu_cond_e;

    typedef struct packed {
        logic [15:0] value;
        logic [3:0] dst_reg;
        logic byte_form;
        logic wr_en;
    } cjmu_wb_s;
endpackage : cjmu_pkg

//--- cjmu_unit.sv
// cjmu_unit: executes relative jumps, the word/byte copy and the idle op.
// assumes software loads the word into the instruction register, then
// writes ctrl.go; instruction words come from program memory via software.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
module cjmu_unit
    import cjmu_pkg::*;
#(
    parameter int unsigned PCW = CJMU_PCW
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // architectural state
    logic [15:0] instr_r;
    logic [PCW-1:0] pc_r;
    logic [15:0] sr_r;
    logic [15:0] regs_r [CJMU_NREG];
    logic [15:0] result_r;
    logic taken_r;
    logic illegal_r;
    logic [7:0] exec_cnt_r;

    // axi bookkeeping
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data accepted in either order
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_r && !s_axi_bvalid;

    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_fire = (aw_hold_r || aw_take) && (w_hold_r || w_take);
    assign wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
    assign wr_data = w_hold_r ? wdata_r : s_axi_wdata;
    assign wr_strb = w_hold_r ? wstrb_r : s_axi_wstrb;

    // a write that lands on a hole still answers, but with slverr
    logic wr_map;
    assign wr_map = (wr_addr == CJMU_ADDR_CTRL) || (wr_addr == CJMU_ADDR_INSTR)
        || (wr_addr == CJMU_ADDR_PC) || (wr_addr == CJMU_ADDR_STATUS)
        || (wr_addr[7:6] == CJMU_ADDR_REGBASE[7:6] && wr_addr[1:0] == 2'h0);

    // hold whichever half arrived first until its partner shows up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    // write response, one outstanding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? 2'h0 : CJMU_RSP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode of the loaded instruction word
    logic go;
    assign go = wr_fire && wr_addr == CJMU_ADDR_CTRL && wr_strb[0] && wr_data[0];

    logic is_jump;
    logic is_copy;
    cjmu_cond_e cond;
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
    logic src_as_ind;
    logic byte_form;
    assign is_jump = instr_r[15:13] == CJMU_JMP_PREFIX;
    assign is_copy = instr_r[15:12] == CJMU_OP_COPY;
    assign cond = cjmu_cond_e'(instr_r[12:10]);
    assign src_reg = instr_r[11:8];
    assign dst_reg = instr_r[3:0];
    // only register-direct and immediate-zero source supported here
    assign src_as_ind = instr_r[5:4] != 2'h0;
    assign byte_form = instr_r[6];

    // flag test per condition code
    logic cond_true;
    always_comb begin
        case (cond)
            CJMU_CND_NZ: cond_true = !sr_r[CJMU_SR_Z];
            CJMU_CND_Z: cond_true = sr_r[CJMU_SR_Z];
            CJMU_CND_NC: cond_true = !sr_r[CJMU_SR_C];
            CJMU_CND_C: cond_true = sr_r[CJMU_SR_C];
            CJMU_CND_N: cond_true = sr_r[CJMU_SR_N];
            CJMU_CND_GE: cond_true = !(sr_r[CJMU_SR_N] ^ sr_r[CJMU_SR_V]);
            // exactly one of negative and overflow
            CJMU_CND_L: cond_true = sr_r[CJMU_SR_N] ^ sr_r[CJMU_SR_V];
            CJMU_CND_AL: cond_true = 1'b1;
            default: cond_true = 1'b0;
        endcase
    end

    // base is the word after the jump
    logic [PCW-1:0] pc_seq;
    logic [PCW-1:0] pc_jump;
    assign pc_seq = pc_r + PCW'(2);
    assign pc_jump = pc_seq + {{(PCW-11){instr_r[9]}}, instr_r[9:0], 1'b0};

    // copy value: source read, never written back to the source
    logic [15:0] src_val;
    cjmu_wb_s wb;
    always_comb begin
        // register 3 as source reads as constant zero
        src_val = (src_reg == CJMU_REG_CG2) ? 16'h0000 : regs_r[src_reg];
        wb.dst_reg = dst_reg;
        wb.byte_form = byte_form;
        // byte form moves the low byte, clearing the high byte
        wb.value = byte_form ? {8'h00, src_val[7:0]} : src_val;
        // writes to the constant register vanish
        wb.wr_en = is_copy && !src_as_ind && dst_reg != CJMU_REG_CG2;
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter and outcome registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_r <= CJMU_PC_RST;
            taken_r <= 1'b0;
            illegal_r <= 1'b0;
            result_r <= 16'h0000;
            exec_cnt_r <= 8'h00;
        end else if (go) begin
            exec_cnt_r <= exec_cnt_r + 8'h01;
            taken_r <= is_jump && cond_true;
            illegal_r <= !(is_jump || (is_copy && !src_as_ind));
            result_r <= wb.value;
            if (is_jump && cond_true) begin
                pc_r <= pc_jump;
            end else begin
                pc_r <= pc_seq;
            end
        end else if (wr_fire && wr_addr == CJMU_ADDR_PC) begin
            pc_r <= {wr_data[PCW-1:1], 1'b0};
        end
    end

    // status word: bus writes and copies into it change it, jumps never do
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sr_r <= CJMU_SR_RST;
        end else if (wr_fire && wr_addr == CJMU_ADDR_STATUS) begin
            sr_r <= wr_data[15:0];
        end else if (go && wb.wr_en && wb.dst_reg == CJMU_REG_SR) begin
            // copy into the status word is a plain store, no flag logic
            // mode bits only change when software names the status word
            sr_r <= wb.value;
        end
    end

    // general registers, one generate lane each
    genvar gi;
    generate
        for (gi = 0; gi < CJMU_NREG; gi++) begin : g_reg
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    regs_r[gi] <= 16'h0000;
                end else if (wr_fire && wr_addr == (CJMU_ADDR_REGBASE + 8'(gi * 4))) begin
                    regs_r[gi] <= wr_data[15:0];
                end else if (go && wb.wr_en && wb.dst_reg == 4'(gi)
                             && 4'(gi) != CJMU_REG_SR) begin
                    regs_r[gi] <= wb.value;
                end
            end
        end
    endgenerate

    // instruction register load
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_r <= 16'h4303;
        end else if (wr_fire && wr_addr == CJMU_ADDR_INSTR) begin
            instr_r <= wr_data[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel, answer one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;

    logic [7:0] ra;
    logic [31:0] rd_val;
    logic rd_map;
    assign ra = s_axi_araddr;
    always_comb begin
        rd_map = 1'b1;
        rd_val = 32'h00000000;
        case (ra)
            CJMU_ADDR_CTRL: rd_val = {24'h000000, exec_cnt_r};
            CJMU_ADDR_INSTR: rd_val = {16'h0000, instr_r};
            CJMU_ADDR_SRCV: rd_val = {16'h0000, src_val};
            CJMU_ADDR_PC: rd_val = 32'(pc_r);
            CJMU_ADDR_STATUS: rd_val = {16'h0000, sr_r};
            CJMU_ADDR_RESULT: rd_val = {14'h0000, illegal_r, taken_r, result_r};
            CJMU_ADDR_INFO: rd_val = CJMU_INFO_ID;
            default: begin
                if (ra[7:6] == CJMU_ADDR_REGBASE[7:6] && ra[1:0] == 2'h0) begin
                    rd_val = {16'h0000, regs_r[ra[5:2]]};
                end else begin
                    rd_map = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_map ? 2'h0 : CJMU_RSP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // cjmu_unit

//--- cjmu_checker.sv
// cjmu_checker: bus assertions for the jump/move unit.
// assumes it is bound to cjmu_unit and sees only its ports.
module cjmu_checker
    import cjmu_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    // answers are tied to the taking edge, so a lost handshake shows at once
    b_follows_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write answer missing");
    b_drops_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not released");
    aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    r_follows_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    r_drops_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr
        inside {[8'h1C:8'h3C]} |=> s_axi_rresp == CJMU_RSP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    id_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr ==
        CJMU_ADDR_INFO |=> s_axi_rdata == CJMU_INFO_ID) else $error("id read wrong");
    pc_even_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr ==
        CJMU_ADDR_PC |=> s_axi_rdata[31:20] == 12'h000 && !s_axi_rdata[0])
        else $error("pc out of range");
endmodule // cjmu_checker

bind cjmu_unit cjmu_checker cjmu_checker_inst (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);

//--- cjmu_prog_mem.sv
// cjmu_prog_mem: program memory giving the copy and idle words.
// assumes addr changes away from clock edges.
module cjmu_prog_mem
    import cjmu_pkg::*;
(
    input wire logic [1:0] addr,
    output logic [15:0] word
);
    // empty slots give a pattern, not a stale word
    always_comb begin
        case (addr)
            2'h0: word = {CJMU_OP_COPY, 4'h5, 4'h0, 4'h7}; // word copy r5 to r7
            2'h1: word = 16'h4547; // byte copy r5 to r7
            2'h2: word = {CJMU_OP_COPY, CJMU_REG_CG2, 4'h0, CJMU_REG_CG2}; // idle
            default: word = 16'h5A5A;
        endcase
    end
endmodule // cjmu_prog_mem

//--- cjmu_unit_tb.sv
// cjmu_unit_tb: drives the unit over axi4-lite and checks jumps and copies.
// assumes the register map and sync active-low reset of cjmu_pkg.
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module cjmu_unit_tb import cjmu_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [15:0] ins; logic [15:0] sr; logic tk;} cjmu_row_s;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [1:0] pm_addr = 2'h0;
    logic [15:0] pm_word;
    logic [19:0] exp;
    int failures = 0, check_count = 0;
    cjmu_row_s rows [16] = '{
        '{16'h39FF, 16'h0004, 1'b1}, '{16'h3A00, 16'h0138, 1'b1},
        '{16'h3805, 16'h0104, 1'b0}, '{16'h3805, 16'h0000, 1'b0},
        '{16'h3C10, 16'h0000, 1'b1}, '{16'h3FF0, 16'h013F, 1'b1},
        '{16'h3003, 16'h0004, 1'b1}, '{16'h3003, 16'h013B, 1'b0},
        '{16'h2BFE, 16'h0000, 1'b1}, '{16'h2BFE, 16'h0001, 1'b0},
        '{16'h2004, 16'h0038, 1'b1}, '{16'h2004, 16'h0002, 1'b0},
        '{16'h2406, 16'h0002, 1'b1}, '{16'h2C06, 16'h0000, 1'b0},
        '{16'h3407, 16'h0104, 1'b1}, '{16'h3407, 16'h0100, 1'b0}};
    cjmu_unit cjmu_unit_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    cjmu_prog_mem cjmu_prog_mem_inst (.addr(pm_addr), .word(pm_word));
    ////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // readies are read at the rising edge, before that edge's updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        n = 0;
        tb = 0;
        while (!tb && n < 40) begin
            @(posedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rsp = s_axi_bresp;
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            n++;
        end
        s_axi_bready <= 0;
        if (!tb) begin failures++; finish_test; end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        int n;
        logic ta, tr;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        n = 0;
        tr = 0;
        while (!tr && n < 40) begin
            @(posedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            rsp = s_axi_rresp;
            if (ta) s_axi_arvalid <= 0;
            n++;
        end
        s_axi_rready <= 0;
        if (!tr) begin failures++; finish_test; end
        `CHK(d, e)
    endtask
    task automatic ex(input logic [15:0] ins);
        wr(CJMU_ADDR_INSTR, {16'h0, ins});
        wr(CJMU_ADDR_CTRL, 32'h1);
    endtask
    initial forever #5 aclk = ~aclk;
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        rdchk(CJMU_ADDR_STATUS, 32'h0);
        rdchk(CJMU_ADDR_INSTR, 32'h4303);
        rdchk(CJMU_ADDR_INFO, CJMU_INFO_ID);
        // pc base is the word after the jump
        foreach (rows[i]) begin
            wr(CJMU_ADDR_PC, 32'h01000);
            wr(CJMU_ADDR_STATUS, {16'h0, rows[i].sr});
            ex(rows[i].ins);
            exp = rows[i].tk ? {{9{rows[i].ins[9]}}, rows[i].ins[9:0], 1'b0} : 20'h0;
            rdchk(CJMU_ADDR_PC, {12'h0, 20'h01002 + exp});
            rdchk(CJMU_ADDR_STATUS, {16'h0, rows[i].sr});
        end
        // copies and idle from program memory; byte form must clear the high byte
        wr(8'h54, 32'hA5C3);
        wr(8'h5C, 32'hFFFF);
        ex(pm_word);
        rdchk(8'h5C, 32'hA5C3);
        rdchk(8'h54, 32'hA5C3);
        pm_addr = 2'h1;
        #1 ex(pm_word);
        rdchk(8'h5C, 32'h00C3);
        rdchk(CJMU_ADDR_RESULT, 32'h00C3);
        pm_addr = 2'h2;
        #1 ex(pm_word);
        rdchk(8'h5C, 32'h00C3);
        rdchk(CJMU_ADDR_STATUS, 32'h0100);
        // back-to-back go on a jump that falls through
        wr(CJMU_ADDR_PC, 32'h01000);
        ex(16'h2404);
        wr(CJMU_ADDR_CTRL, 32'h1);
        rdchk(CJMU_ADDR_PC, 32'h01004);
        wr(8'h1C, 32'h1);
        `CHK(rsp, CJMU_RSP_SLVERR)
        rdchk(8'h1C, 32'h0);
        `CHK(rsp, CJMU_RSP_SLVERR)
        // reset in mid-run clears the counter
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rdchk(CJMU_ADDR_PC, 32'h0);
        rdchk(CJMU_ADDR_CTRL, 32'h0);
        finish_test;
    end
endmodule // cjmu_unit_tb
